// >>> bench/fabric_model.sv
`timescale 1ns/100ps
module fabric_model (
    // Clock.
    input wire logic clk,
    // Routed inputs of the unit.
    output tcpu_pkg::route_in_t route_in
);
    // ----
    // Drivers
    // ----
    initial route_in = '0;
    // Events change only after an edge, last four cycles and then rest four,
    // so that the synchroniser sees exactly one rising edge per call even
    // when calls follow back to back.
    task automatic pulse(input int b);
        @(posedge clk);
        route_in[b] <= 1'b1;
        repeat (4) @(posedge clk);
        route_in[b] <= 1'b0;
        repeat (4) @(posedge clk);
    endtask : pulse
    task automatic level(input int b, input logic v);
        @(posedge clk);
        route_in[b] <= v;
    endtask : level
endmodule : fabric_model

// >>> bench/tb_timer_count_pulse_unit.sv
`timescale 1ns/100ps
module tb_timer_count_pulse_unit;
    typedef struct packed {logic we; logic [3:0] a; logic [31:0] d; logic [31:0] e;} row_t;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [5:0] avs_address = '0;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = '0;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    tcpu_pkg::route_in_t route_in;
    tcpu_pkg::route_out_t route_out;
    logic irq;
    int err_total = 0;
    int cmp_count = 0;
    int hi, rs, h2;
    int exp_hi[5] = '{5, 6, 1, 5, 4};
    row_t rows[11] = '{'{0, 4'h0, 0, 0}, '{0, 4'h1, 0, 32'hFFFF}, '{0, 4'h2, 0, 32'h8000},
        '{0, 4'h3, 0, 0}, '{0, 4'h5, 0, 0}, '{0, 4'h6, 0, 0}, '{0, 4'h7, 0, 0},
        '{1, 4'h9, 32'h1234, 0}, '{1, 4'h3, 32'h55, 0}, '{1, 4'h7, 32'h1FF, 32'hFF},
        '{1, 4'h6, 32'hF, 32'h7}};

    always #10 clk = ~clk;

    fabric_model fab (.clk(clk), .route_in(route_in));
    timer_count_pulse_unit DUT (.clk(clk), .rst(rst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .route_in(route_in), .route_out(route_out), .irq(irq));

    // ----
    // Helpers
    // ----
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_total++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    // Wait and read data are taken as they stood just before each rising
    // edge, since the slave only changes them by non-blocking updates.
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d,
        output logic [31:0] q);
        @(posedge clk);
        avs_address <= {a, 2'b00};
        avs_write <= w;
        avs_read <= ~w;
        avs_writedata <= d;
        @(posedge clk);
        while (avs_waitrequest !== 1'b0) @(posedge clk);
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask : bus
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask : wr
    task automatic rdck(input logic [3:0] a, input logic [31:0] e);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, q);
        check(q, e);
    endtask : rdck
    task automatic tally(input int b, input int n, output int h, output int r);
        logic p;
        repeat (4) @(negedge clk);
        h = 0;
        r = 0;
        p = route_out[b];
        repeat (n) begin
            @(negedge clk);
            h += route_out[b];
            r += (route_out[b] && !p);
            p = route_out[b];
        end
    endtask : tally
    function automatic logic [31:0] cw(input tcpu_pkg::mode_t m, input tcpu_pkg::cmp_t c,
        input tcpu_pkg::clk_sel_t k, input logic inv);
        return 32'h201 | {23'h0, k, inv, c, m, 1'b0};
    endfunction : cw
    task automatic wrap_up;
        $display("compares %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : wrap_up

    initial begin
        #400000;
        err_total++;
        wrap_up();
    end

    initial begin
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        foreach (rows[i]) begin
            if (rows[i].we) wr(rows[i].a, rows[i].d);
            rdck(rows[i].a, rows[i].e);
        end
        $display("registers done");
        wr(4'h6, 32'h0);
        wr(4'h1, 32'h9);
        wr(4'h2, 32'h5);
        for (int c = 0; c < 5; c++) begin
            wr(4'h0, cw(tcpu_pkg::MODE_FREE, tcpu_pkg::cmp_t'(c), tcpu_pkg::CLK_SYS, 1'b0));
            tally(3, 10, hi, rs);
            check(hi, exp_hi[c]);
            tally(2, 20, hi, rs);
            check(rs, 2);
        end
        wr(4'h0, cw(tcpu_pkg::MODE_FREE, tcpu_pkg::CMP_EQ, tcpu_pkg::CLK_SYS, 1'b1));
        tally(2, 10, hi, rs);
        check(hi, 9);
        fab.level(1, 1'b1);
        repeat (2) @(posedge clk);
        tally(3, 10, hi, rs);
        check(hi, 0);
        fab.level(1, 1'b0);
        wr(4'h7, 32'h2);
        wr(4'h0, cw(tcpu_pkg::MODE_FREE, tcpu_pkg::CMP_GTE, tcpu_pkg::CLK_SYS, 1'b0));
        tally(1, 10, hi, rs);
        tally(0, 10, h2, rs);
        check(hi + h2, 6);
        for (int k = 1; k < 3; k++) begin
            wr(4'h0, cw(tcpu_pkg::MODE_FREE, tcpu_pkg::CMP_EQ, tcpu_pkg::clk_sel_t'(k), 1'b0));
            tally(2, 40 * k, hi, rs);
            check(rs, 2);
        end
        wr(4'h0, cw(tcpu_pkg::MODE_FREE, tcpu_pkg::CMP_EQ, tcpu_pkg::CLK_EXT, 1'b0));
        repeat (3) fab.pulse(0);
        rdck(4'h3, 32'h6);
        $display("compare and clock done");
        wr(4'h0, cw(tcpu_pkg::MODE_FREE, tcpu_pkg::CMP_EQ, tcpu_pkg::CLK_SYS, 1'b0));
        repeat (25) @(negedge clk);
        check(irq, 1'b0);
        rdck(4'h5, 32'h3);
        wr(4'h6, 32'h1);
        repeat (12) @(negedge clk);
        check(irq, 1'b1);
        wr(4'h0, cw(tcpu_pkg::MODE_ONESHOT, tcpu_pkg::CMP_EQ, tcpu_pkg::CLK_SYS, 1'b0));
        tally(2, 20, hi, rs);
        check(rs, 1);
        rdck(4'h3, 32'h0);
        rdck(4'h0, 32'h13);
        rdck(4'h5, 32'h3);
        @(negedge clk);
        check(irq, 1'b0);
        $display("interrupt and one-shot done");
        wr(4'h1, 32'h1234);
        wr(4'h0, cw(tcpu_pkg::MODE_GATED, tcpu_pkg::CMP_EQ, tcpu_pkg::CLK_SYS, 1'b0));
        repeat (8) @(posedge clk);
        rdck(4'h3, 32'h1234);
        fab.level(4, 1'b1);
        repeat (9) @(posedge clk);
        fab.level(4, 1'b0);
        repeat (8) @(posedge clk);
        rdck(4'h3, 32'h122A);
        fab.pulse(2);
        repeat (8) @(posedge clk);
        rdck(4'h4, 32'h122A);
        fab.pulse(3);
        repeat (8) @(posedge clk);
        rdck(4'h3, 32'h1234);
        $display("gated capture reload done");
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        rdck(4'h1, 32'hFFFF);
        rdck(4'h4, 32'h0);
        check(route_out, 4'h0);
        $display("mid-run reset done");
        wrap_up();
    end
endmodule : tb_timer_count_pulse_unit

// >>> bench/timer_count_pulse_unit_properties.sv
`timescale 1ns/100ps
module tcpu_checker (
    // Clock and reset.
    input wire logic clk,
    input wire logic rst,
    // Register bus.
    input wire logic [tcpu_pkg::ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    // Fabric and interrupt.
    input wire tcpu_pkg::route_in_t route_in,
    input wire tcpu_pkg::route_out_t route_out,
    input wire logic irq
);
    // ----
    // Properties
    // ----
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    wire logic req = avs_read | avs_write;
    wire logic rdone = avs_read & ~avs_waitrequest;
    wire logic done = req & ~avs_waitrequest;

    wait_one_a: assert property (req && avs_waitrequest |=> !avs_waitrequest)
        else $error("bus access waited more than one cycle");
    wait_idle_a: assert property (!req |-> !avs_waitrequest)
        else $error("wait raised with no request");
    rdata_hold_a: assert property (rdone |=> $stable(avs_readdata))
        else $error("read data moved after the access");
    count_width_a: assert property (rdone && avs_address[5:2] == tcpu_pkg::ADDR_COUNT
        |-> avs_readdata[31:16] == 16'h0000)
        else $error("count wider than sixteen bits");
    unmapped_zero_a: assert property (rdone && avs_address[5] |-> avs_readdata == 32'h0)
        else $error("unmapped read not zero");
    kill_force_a: assert property (route_in.kill [*6]
        |-> !route_out.compare && !route_out.pwm_hi && !route_out.pwm_lo)
        else $error("outputs active under kill");
    pwm_pair_a: assert property (!(route_out.pwm_hi && route_out.pwm_lo))
        else $error("both pwm outputs high");
    db_width_a: assert property (rdone && avs_address[5:2] == tcpu_pkg::ADDR_DEADBAND
        |-> avs_readdata[31:8] == 24'h0)
        else $error("deadband wider than eight bits");
    reset_quiet_a: assert property ($fell(rst) |-> route_out == '0 && !irq)
        else $error("outputs active after reset");
    irq_sticky_a: assert property ($fell(irq) |-> $past(done))
        else $error("interrupt dropped with no bus access");
    cover property (route_in.kill [*6]);
    cover property (irq);
    cover property ($rose(route_out.terminal));
endmodule : tcpu_checker

bind timer_count_pulse_unit tcpu_checker chk (.clk(clk), .rst(rst),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .route_in(route_in), .route_out(route_out),
    .irq(irq));

// >>> rtl/tcpu_pkg.sv
package tcpu_pkg;

    // ------------------------------------------------------------------
    // Register map (word indices; byte address is index times four).
    // ------------------------------------------------------------------
    localparam logic [3:0] ADDR_CTRL = 4'h0;
    localparam logic [3:0] ADDR_PERIOD = 4'h1;
    localparam logic [3:0] ADDR_COMPARE = 4'h2;
    localparam logic [3:0] ADDR_COUNT = 4'h3;
    localparam logic [3:0] ADDR_CAPTURE = 4'h4;
    localparam logic [3:0] ADDR_STATUS = 4'h5;
    localparam logic [3:0] ADDR_MASK = 4'h6;
    localparam logic [3:0] ADDR_DEADBAND = 4'h7;
    localparam int ADDR_W = 6;
    localparam int WORD_LSB = 2;

    // ------------------------------------------------------------------
    // Field layout of the control register.
    // ------------------------------------------------------------------
    localparam int CTRL_EN = 0;
    localparam int CTRL_MODE_LO = 1;
    localparam int CTRL_CMP_LO = 3;
    localparam int CTRL_TC_CMPL = 6;
    localparam int CTRL_CLK_LO = 7;
    localparam int CTRL_START = 9;
    localparam int CTRL_W = 9;

    // Status and mask bit positions.
    localparam int ST_TC = 0;
    localparam int ST_CMP = 1;
    localparam int ST_CAP = 2;
    localparam int ST_W = 3;

    localparam logic [15:0] PERIOD_RST = 16'hFFFF;
    localparam logic [15:0] COMPARE_RST = 16'h8000;
    localparam logic [15:0] COUNT_ZERO = 16'h0000;
    localparam logic [7:0] DEADBAND_RST = 8'h00;
    localparam logic [7:0] DB_ZERO = 8'h00;
    localparam logic [7:0] DB_ONE = 8'h01;
    localparam logic [15:0] COUNT_ONE = 16'h0001;

    // ------------------------------------------------------------------
    // Types.
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        MODE_FREE,
        MODE_ONESHOT,
        MODE_GATED
    } mode_t;

    typedef enum logic [2:0] {
        CMP_LT,
        CMP_LTE,
        CMP_EQ,
        CMP_GTE,
        CMP_GT
    } cmp_t;

    typedef enum logic [1:0] {
        CLK_SYS,
        CLK_DIV2,
        CLK_DIV4,
        CLK_EXT
    } clk_sel_t;

    typedef struct packed {
        logic enable;
        logic reload;
        logic capture;
        logic kill;
        logic ext_tick;
    } route_in_t;

    typedef struct packed {
        logic compare;
        logic terminal;
        logic pwm_hi;
        logic pwm_lo;
    } route_out_t;

endpackage : tcpu_pkg

// >>> rtl/timer_count_pulse_unit.sv
// Design decisions made here: register access over Avalon-MM and the address map.
`timescale 1ns/100ps

// Functional notes
// - Sixteen-bit counter counts down only, on the selected clock.
// - Compare output from counter vs compare value: LT, LTE, EQ, GTE, GT.
// - Period loaded on start, on the routed reload input, and at terminal count in free-run and gated modes.
// - Interrupt sources terminal count, compare true, capture, each maskable.
// - One-shot runs one period and then stops without reloading.
// - Gated mode decrements only while routed enable is high.
// - Compare, terminal count outputs, interrupt; terminal may carry inverted compare.
// - Kill forces comparator-driven outputs inactive while asserted.
// - Capture event stores full counter value in a capture register.
// - Complementary PWM pair with programmable deadband.
// - Counting clock selectable; routed inputs and outputs via fabric.
// - Free-run, one-shot and gated modes chosen by configuration.
module timer_count_pulse_unit (
    // Clock and reset.
    input wire logic clk,
    input wire logic rst,
    // Avalon-MM slave.
    input wire logic [tcpu_pkg::ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // Routing fabric.
    input wire tcpu_pkg::route_in_t route_in,
    output tcpu_pkg::route_out_t route_out,
    // Interrupt.
    output logic irq
);

    // ------------------------------------------------------------------
    // Input synchronisers: three stages, a change counts when 2 and 3 agree.
    // ------------------------------------------------------------------
    tcpu_pkg::route_in_t s1_r;
    tcpu_pkg::route_in_t s2_r;
    tcpu_pkg::route_in_t s3_r;
    tcpu_pkg::route_in_t in_r;
    tcpu_pkg::route_in_t in_prev_r;

    // Routed signals may come straight from pins on another clock, so every
    // bit is resynchronised; the cost is four cycles of input latency.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s1_r <= '0;
            s2_r <= '0;
            s3_r <= '0;
        end else begin
            s1_r <= route_in;
            s2_r <= s1_r;
            s3_r <= s2_r;
        end
    end

    // Filtered value follows only when the last two stages agree.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            in_r <= '0;
            in_prev_r <= '0;
        end else begin
            if (s2_r == s3_r) begin
                in_r <= s3_r;
            end
            in_prev_r <= in_r;
        end
    end

    // Rising edges of routed events; each is seen exactly once.
    // Levels that stay high do not retrigger, so a slow source that holds
    // its line for many cycles still produces a single event.
    function automatic logic edge_rise(input logic now_v, input logic was_v);
        edge_rise = now_v & ~was_v;
    endfunction : edge_rise

    logic reload_ev;
    logic capture_ev;
    logic tick_ev;
    assign reload_ev = edge_rise(in_r.reload, in_prev_r.reload);
    assign capture_ev = edge_rise(in_r.capture, in_prev_r.capture);
    assign tick_ev = edge_rise(in_r.ext_tick, in_prev_r.ext_tick);

    // ------------------------------------------------------------------
    // Registers.
    // ------------------------------------------------------------------
    logic [tcpu_pkg::CTRL_W-1:0] ctrl_r;
    logic [15:0] period_r;
    logic [15:0] compare_r;
    logic [15:0] count_r;
    logic [15:0] capture_r;
    logic [tcpu_pkg::ST_W-1:0] status_r;
    logic [tcpu_pkg::ST_W-1:0] mask_r;
    logic [7:0] deadband_r;
    logic running_r;
    logic [1:0] div_r;
    logic ack_r;

    tcpu_pkg::mode_t mode;
    tcpu_pkg::cmp_t cmp_sel;
    tcpu_pkg::clk_sel_t clk_sel;
    assign mode = tcpu_pkg::mode_t'(ctrl_r[tcpu_pkg::CTRL_MODE_LO +: 2]);
    assign cmp_sel = tcpu_pkg::cmp_t'(ctrl_r[tcpu_pkg::CTRL_CMP_LO +: 3]);
    assign clk_sel = tcpu_pkg::clk_sel_t'(ctrl_r[tcpu_pkg::CTRL_CLK_LO +: 2]);

    // ------------------------------------------------------------------
    // Register bus.
    // ------------------------------------------------------------------
    // Bus decode. Every access takes one wait cycle, so read data comes
    // from a flop and side effects happen exactly once.
    // A master that holds its request past the cycle with wait low would
    // start a second access; the handshake leaves that to the master.
    logic [3:0] widx;
    logic wr_go;
    logic rd_go;
    assign widx = avs_address[tcpu_pkg::ADDR_W-1:tcpu_pkg::WORD_LSB];
    assign wr_go = avs_write & ack_r;
    assign rd_go = avs_read & ack_r;
    assign avs_waitrequest = (avs_read | avs_write) & ~ack_r;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ack_r <= 1'b0;
        end else begin
            ack_r <= (avs_read | avs_write) & ~ack_r;
        end
    end

    // The start bit is not stored: writing it loads the period once and
    // sets the run flag. A reload edge in the same cycle loads the same value.
    logic start_wr;
    assign start_wr = wr_go && widx == tcpu_pkg::ADDR_CTRL
        && avs_writedata[tcpu_pkg::CTRL_START];

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ctrl_r <= '0;
            period_r <= tcpu_pkg::PERIOD_RST;
            compare_r <= tcpu_pkg::COMPARE_RST;
            mask_r <= '0;
            deadband_r <= tcpu_pkg::DEADBAND_RST;
        end else if (wr_go) begin
            case (widx)
                tcpu_pkg::ADDR_CTRL: ctrl_r <= avs_writedata[tcpu_pkg::CTRL_W-1:0];
                tcpu_pkg::ADDR_PERIOD: period_r <= avs_writedata[15:0];
                tcpu_pkg::ADDR_COMPARE: compare_r <= avs_writedata[15:0];
                tcpu_pkg::ADDR_MASK: mask_r <= avs_writedata[tcpu_pkg::ST_W-1:0];
                tcpu_pkg::ADDR_DEADBAND: deadband_r <= avs_writedata[7:0];
                default: ;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Clock source selection: count strobe per selected source.
    // ------------------------------------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            div_r <= 2'h0;
        end else begin
            div_r <= div_r + 2'h1;
        end
    end

    // Divided sources are strobes on the system clock, not derived clocks, so
    // the whole block stays in one domain. The divider runs freely, so the
    // first strobe after a start may come early by up to one source period.
    logic clk_tick;
    always_comb begin
        case (clk_sel)
            tcpu_pkg::CLK_SYS: clk_tick = 1'b1;
            tcpu_pkg::CLK_DIV2: clk_tick = div_r[0];
            tcpu_pkg::CLK_DIV4: clk_tick = &div_r;
            tcpu_pkg::CLK_EXT: clk_tick = tick_ev;
            default: clk_tick = 1'b0;
        endcase
    end

    // ------------------------------------------------------------------
    // Counter.
    // ------------------------------------------------------------------
    logic enabled;
    logic step;
    logic at_tc;
    assign enabled = ctrl_r[tcpu_pkg::CTRL_EN];
    // Gated mode also needs the enable input; other modes ignore it.
    assign step = enabled && running_r && clk_tick
        && (mode != tcpu_pkg::MODE_GATED || in_r.enable);
    // Terminal count is the tick taken at zero, so one cycle lasts the period
    // value plus one ticks.
    assign at_tc = count_r == tcpu_pkg::COUNT_ZERO;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            count_r <= tcpu_pkg::COUNT_ZERO;
            running_r <= 1'b0;
        end else if (start_wr || reload_ev) begin
            count_r <= period_r;
            running_r <= 1'b1;
        end else if (step) begin
            if (at_tc) begin
                // One-shot parks at zero; a new start write or reload edge
                // is the only way to run it again.
                if (mode == tcpu_pkg::MODE_ONESHOT) begin
                    running_r <= 1'b0;
                end else begin
                    count_r <= period_r;
                end
            end else begin
                count_r <= count_r - tcpu_pkg::COUNT_ONE;
            end
        end
    end

    logic tc_ev;
    assign tc_ev = step && at_tc;

    // ------------------------------------------------------------------
    // Compare, capture and outputs.
    // ------------------------------------------------------------------
    function automatic logic cmp_eval(input tcpu_pkg::cmp_t sel, input logic [15:0] a,
                                      input logic [15:0] b);
        case (sel)
            tcpu_pkg::CMP_LT: cmp_eval = a < b;
            tcpu_pkg::CMP_LTE: cmp_eval = a <= b;
            tcpu_pkg::CMP_EQ: cmp_eval = a == b;
            tcpu_pkg::CMP_GTE: cmp_eval = a >= b;
            tcpu_pkg::CMP_GT: cmp_eval = a > b;
            default: cmp_eval = 1'b0;
        endcase
    endfunction : cmp_eval

    logic cmp_raw;
    assign cmp_raw = enabled && cmp_eval(cmp_sel, count_r, compare_r);

    // ------------------------------------------------------------------
    // Capture.
    // ------------------------------------------------------------------
    // The value taken is the count as the synchronised edge arrives, which
    // lags the event on the line by the synchroniser latency.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            capture_r <= tcpu_pkg::COUNT_ZERO;
        end else if (capture_ev) begin
            capture_r <= count_r;
        end
    end

    // ------------------------------------------------------------------
    // Complementary outputs.
    // ------------------------------------------------------------------
    // Deadband: after either phase drops, both stay low for deadband_r cycles.
    // A compare that toggles faster than the deadband keeps both phases low.
    logic [7:0] db_cnt_r;
    logic cmp_q_r;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            db_cnt_r <= tcpu_pkg::DB_ZERO;
            cmp_q_r <= 1'b0;
        end else begin
            cmp_q_r <= cmp_raw;
            if (cmp_raw != cmp_q_r) begin
                db_cnt_r <= deadband_r;
            end else if (db_cnt_r != tcpu_pkg::DB_ZERO) begin
                db_cnt_r <= db_cnt_r - tcpu_pkg::DB_ONE;
            end
        end
    end

    logic db_hold;
    assign db_hold = (cmp_raw != cmp_q_r && deadband_r != tcpu_pkg::DB_ZERO)
        || db_cnt_r > tcpu_pkg::DB_ONE;

    // All routed outputs are registered so that downstream logic sees no
    // glitches from the comparator; they lag the count by one cycle.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            route_out <= '0;
        end else begin
            // Kill overrides everything the comparator drives.
            route_out.compare <= cmp_raw & ~in_r.kill;
            route_out.terminal <= ctrl_r[tcpu_pkg::CTRL_TC_CMPL]
                ? (~cmp_raw & enabled & ~in_r.kill) : tc_ev;
            route_out.pwm_hi <= cmp_raw & ~db_hold & ~in_r.kill;
            route_out.pwm_lo <= enabled & ~cmp_raw & ~db_hold & ~in_r.kill;
        end
    end

    // ------------------------------------------------------------------
    // Interrupt status: sticky, cleared by reading; a new event wins.
    // ------------------------------------------------------------------
    // A compare event is the rising edge of the condition, so a level that
    // stays true raises the status bit only once per crossing.
    logic [tcpu_pkg::ST_W-1:0] ev_vec;
    logic cmp_prev_r;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cmp_prev_r <= 1'b0;
        end else begin
            cmp_prev_r <= cmp_raw;
        end
    end
    always_comb begin
        ev_vec = '0;
        ev_vec[tcpu_pkg::ST_TC] = tc_ev;
        ev_vec[tcpu_pkg::ST_CMP] = edge_rise(cmp_raw, cmp_prev_r);
        ev_vec[tcpu_pkg::ST_CAP] = capture_ev;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            status_r <= '0;
        end else if (rd_go && widx == tcpu_pkg::ADDR_STATUS) begin
            // Only bits that the read returned are cleared: an event that
            // lands after the data was latched, or in this very cycle, stays.
            status_r <= (status_r & ~avs_readdata[tcpu_pkg::ST_W-1:0]) | ev_vec;
        end else begin
            status_r <= status_r | ev_vec;
        end
    end

    // The request is a level: it stays high until software reads the status
    // or masks the cause, so no event is lost between two interrupts.
    assign irq = |(status_r & mask_r);

    // ------------------------------------------------------------------
    // Read mux.
    // ------------------------------------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            avs_readdata <= '0;
        // Data is latched in the first cycle of a read; the control word
        // returns its low byte with the run flag above it.
        end else if (avs_read & ~ack_r) begin
            case (widx)
                tcpu_pkg::ADDR_CTRL: avs_readdata <= {23'h0, running_r, ctrl_r[7:0]};
                tcpu_pkg::ADDR_PERIOD: avs_readdata <= {16'h0, period_r};
                tcpu_pkg::ADDR_COMPARE: avs_readdata <= {16'h0, compare_r};
                tcpu_pkg::ADDR_COUNT: avs_readdata <= {16'h0, count_r};
                tcpu_pkg::ADDR_CAPTURE: avs_readdata <= {16'h0, capture_r};
                tcpu_pkg::ADDR_STATUS: avs_readdata <= {29'h0, status_r};
                tcpu_pkg::ADDR_MASK: avs_readdata <= {29'h0, mask_r};
                tcpu_pkg::ADDR_DEADBAND: avs_readdata <= {24'h0, deadband_r};
                default: avs_readdata <= '0;
            endcase
        end
    end

endmodule : timer_count_pulse_unit
